// >>> srr_pkg.sv
// shared constants and types for the soft row repair block
package srr_pkg;
  localparam int NBANK = 16;
  localparam int ROW_W = 18;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MPR2_OFS = 8'h08;
  localparam logic [7:0] MPR3_OFS = 8'h0C;
  localparam logic [1:0] REP_PAGE = 2'h1;
  // control fields
  localparam int CTRL_HARD_BIT = 0;
  localparam int CTRL_SOFT_BIT = 1;
  localparam int CTRL_MBIST_BIT = 2;
  localparam int CTRL_BYPASS_BIT = 3;
  localparam int CTRL_WL_LSB = 8;
  localparam int WL_W = 5;
  localparam logic [31:0] CTRL_RST = 32'h0000_0903;
  // status fields
  localparam int STAT_MODE_BIT = 0;
  localparam int STAT_DONE_BIT = 4;
  localparam int STAT_UNDEF_BIT = 5;
  localparam int STAT_REFERR_BIT = 6;
  localparam int STAT_OPEN_LSB = 16;
  // mode register decode
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [2:0] MR4_SEL = 3'h4;
  localparam int MR4_SPPR_BIT = 5;
  localparam int AP_BIT = 10;
  localparam logic [6:0] KEY_LOW = 7'h7F;
  localparam logic [4:0] KEY1 = 5'h19;
  localparam logic [4:0] KEY2 = 5'h0F;
  localparam logic [4:0] KEY3 = 5'h17;
  localparam logic [4:0] KEY4 = 5'h07;
  // burst: 8 beats, first 4 beats are the two-clock high window
  localparam logic [2:0] LAST_BEAT = 3'h7;
  localparam logic [2:0] HIGH_BEATS = 3'h3;
  // ck rises after the write latency before auto precharge closes a bank
  localparam logic [5:0] AP_TAIL = 6'h06;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD
  } srr_cmd_type;

  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
    logic [7:0] dq;
  } srr_pins_type;
endpackage : srr_pkg

// >>> srr_core.sv
// sdram soft row repair command logic with axi4-lite status and control
`timescale 1ns/100ps
`default_nettype none

module srr_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [17:0] addr,
  input wire logic [7:0] dq,
  input wire logic [srr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [srr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import srr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_KEYS, ST_ARMED, ST_OPEN, ST_WLAT, ST_BURST, ST_DONE
  } srr_state_type;

  // link pins pass two flops before use; edges come from the synced ck
  srr_pins_type pins_m_ff, pins_s_ff;
  logic ck_m_ff, ck_s_ff, ck_d_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins_m_ff <= '1;
      pins_s_ff <= '1;
      ck_m_ff <= 1'b0;
      ck_s_ff <= 1'b0;
      ck_d_ff <= 1'b0;
    end else begin
      pins_m_ff <= {cs_n, act_n, bg, ba, addr, dq};
      pins_s_ff <= pins_m_ff;
      ck_m_ff <= ck;
      ck_s_ff <= ck_m_ff;
      ck_d_ff <= ck_s_ff;
    end
  end

  logic ck_rise, ck_edge;
  assign ck_rise = ck_s_ff & ~ck_d_ff;
  assign ck_edge = ck_s_ff ^ ck_d_ff;

  // command decode at each ck rise
  srr_cmd_type cmd;
  logic [3:0] bank;
  logic [2:0] mr_sel;
  always_comb begin
    cmd = CMD_NONE;
    if (ck_rise && !pins_s_ff.cs_n) begin
      if (!pins_s_ff.act_n) begin
        cmd = CMD_ACT;
      end else begin
        case (pins_s_ff.addr[16:14])
          3'b000: cmd = CMD_MRS;
          3'b001: cmd = CMD_REF;
          3'b010: cmd = CMD_PRE;
          3'b100: cmd = CMD_WR;
          3'b101: cmd = CMD_RD;
          3'b111: cmd = CMD_NOP;
          default: cmd = CMD_NOP;
        endcase
      end
    end
  end
  assign bank = {pins_s_ff.bg, pins_s_ff.ba};
  assign mr_sel = {pins_s_ff.bg[0], pins_s_ff.ba};

  logic [31:0] ctrl_ff;
  logic [WL_W-1:0] wl;
  assign wl = ctrl_ff[CTRL_WL_LSB +: WL_W];

  logic mr4_wr, key_ok;
  logic [1:0] key_idx_ff;
  logic [4:0] key_exp;
  assign mr4_wr = (cmd == CMD_MRS) && (mr_sel == MR4_SEL)
                  && !pins_s_ff.bg[1];
  always_comb begin
    case (key_idx_ff)
      2'd0: key_exp = KEY1;
      2'd1: key_exp = KEY2;
      2'd2: key_exp = KEY3;
      default: key_exp = KEY4;
    endcase
  end
  assign key_ok = (cmd == CMD_MRS) && (mr_sel == MR0_SEL)
                  && !pins_s_ff.bg[1]
                  && (pins_s_ff.addr[6:0] == KEY_LOW)
                  && (pins_s_ff.addr[11:7] == key_exp);

  // soft repair mode flag follows every mode register 4 write
  logic mode_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_ff <= 1'b0;
    end else if (mr4_wr) begin
      mode_ff <= pins_s_ff.addr[MR4_SPPR_BIT];
    end
  end

  srr_state_type st_ff;
  logic [WL_W-1:0] wl_cnt_ff;
  logic [2:0] beat_ff;
  logic [3:0] tbank_ff;
  logic [ROW_W-1:0] trow_ff;
  logic all_low_ff, all_high_ff, take_beat, beat_low, beat_high;
  logic commit, finish;
  assign take_beat = (st_ff == ST_WLAT && ck_rise && wl_cnt_ff == 5'd1)
                     || (st_ff == ST_BURST && ck_edge);
  assign beat_low = (pins_s_ff.dq == 8'h00);
  assign beat_high = (pins_s_ff.dq == 8'hFF);
  assign finish = take_beat && (beat_ff == LAST_BEAT);
  assign commit = finish && all_low_ff && beat_low;

  // any command but deselect up to the write breaks the key and repair sequence
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= ST_IDLE;
      key_idx_ff <= 2'd0;
    end else if (mr4_wr) begin
      key_idx_ff <= 2'd0;
      if (!pins_s_ff.addr[MR4_SPPR_BIT]) begin
        st_ff <= ST_IDLE;
      end else if (ctrl_ff[CTRL_BYPASS_BIT]) begin
        st_ff <= ST_ARMED;
      end else begin
        st_ff <= ST_KEYS;
      end
    end else begin
      case (st_ff)
        ST_KEYS: begin
          if (key_ok) begin
            key_idx_ff <= key_idx_ff + 2'd1;
            if (key_idx_ff == 2'd3) begin
              st_ff <= ST_ARMED;
            end
          end else if (cmd != CMD_NONE) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_ARMED: begin
          if (cmd == CMD_ACT) begin
            st_ff <= ST_OPEN;
          end else if (cmd != CMD_NONE) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_OPEN: begin
          if (cmd == CMD_WR && bank == tbank_ff) begin
            st_ff <= ST_WLAT;
          end else if (cmd != CMD_NONE) begin
            st_ff <= ST_IDLE;
          end
        end
        ST_WLAT: begin
          if (take_beat) begin
            st_ff <= ST_BURST;
          end
        end
        ST_BURST: begin
          if (finish) begin
            st_ff <= ST_DONE;
          end
        end
        ST_DONE: st_ff <= ST_DONE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // failing bank and row are caught at the armed activate
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tbank_ff <= 4'h0;
      trow_ff <= '0;
    end else if (st_ff == ST_ARMED && cmd == CMD_ACT && !mr4_wr) begin
      tbank_ff <= bank;
      trow_ff <= pins_s_ff.addr;
    end
  end

  // write latency counted in ck rises, then eight beats on both ck edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wl_cnt_ff <= '0;
    end else if (st_ff == ST_OPEN && cmd == CMD_WR) begin
      wl_cnt_ff <= wl;
    end else if (st_ff == ST_WLAT && ck_rise && wl_cnt_ff != 5'd1) begin
      wl_cnt_ff <= wl_cnt_ff - 5'd1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      beat_ff <= 3'd0;
      all_low_ff <= 1'b1;
      all_high_ff <= 1'b1;
    end else if (st_ff != ST_WLAT && st_ff != ST_BURST) begin
      beat_ff <= 3'd0;
      all_low_ff <= 1'b1;
      all_high_ff <= 1'b1;
    end else if (take_beat) begin
      beat_ff <= beat_ff + 3'd1;
      all_low_ff <= all_low_ff & beat_low;
      if (beat_ff <= HIGH_BEATS) begin
        all_high_ff <= all_high_ff & beat_high;
      end
    end
  end

  // outcome flags; a mixed pattern is undefined and never repairs
  logic done_ff, undef_ff, referr_ff;
  logic stat_clr;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_ff <= 1'b0;
      undef_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= commit;
      undef_ff <= !commit && !all_high_ff;
    end else if (stat_clr) begin
      done_ff <= 1'b0;
      undef_ff <= 1'b0;
    end
  end

  // refresh in repair mode or with an open bank is flagged; set wins
  logic [NBANK-1:0] open_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      referr_ff <= 1'b0;
    end else if (cmd == CMD_REF && (mode_ff || open_ff != '0)) begin
      referr_ff <= 1'b1;
    end else if (stat_clr) begin
      referr_ff <= 1'b0;
    end
  end

  // per bank: open row, auto precharge timer, held repair entry
  logic [NBANK-1:0] rep_valid;
  logic [ROW_W-1:0] rep_row [NBANK];
  logic [NBANK-1:0] ap_due;
  genvar gi;
  for (gi = 0; gi < NBANK; gi++) begin : g_bank
    logic [5:0] ap_cnt_ff;
    logic ap_on_ff, vld_ff;
    logic [ROW_W-1:0] row_ff;
    logic hit;
    assign hit = (bank == 4'(gi));
    assign ap_due[gi] = ap_on_ff && ap_cnt_ff == 6'd0;
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        open_ff[gi] <= 1'b0;
      end else if (cmd == CMD_ACT && hit) begin
        open_ff[gi] <= 1'b1;
      end else if (cmd == CMD_PRE && (hit || pins_s_ff.addr[AP_BIT])) begin
        open_ff[gi] <= 1'b0;
      end else if (ap_due[gi]) begin
        open_ff[gi] <= 1'b0;
      end
    end
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        ap_on_ff <= 1'b0;
        ap_cnt_ff <= 6'd0;
      end else if ((cmd == CMD_WR || cmd == CMD_RD) && hit
                   && pins_s_ff.addr[AP_BIT]) begin
        ap_on_ff <= 1'b1;
        ap_cnt_ff <= 6'(wl) + AP_TAIL;
      end else if (ap_due[gi] || (cmd == CMD_PRE && hit)) begin
        ap_on_ff <= 1'b0;
      end else if (ap_on_ff && ck_rise) begin
        ap_cnt_ff <= ap_cnt_ff - 6'd1;
      end
    end
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        vld_ff <= 1'b0;
        row_ff <= '0;
      end else if (commit && tbank_ff == 4'(gi)) begin
        vld_ff <= 1'b1;
        row_ff <= trow_ff;
      end
    end
    assign rep_valid[gi] = vld_ff;
    assign rep_row[gi] = row_ff;
    // tied to this bank so a later command cannot move the target
    a_ap_closes: assert property (@(posedge clk) disable iff (reset)
      (cmd == CMD_WR || cmd == CMD_RD) && hit && pins_s_ff.addr[AP_BIT]
      && open_ff[gi] |-> ##[1:900] !open_ff[gi])
      else $error("auto precharge never closed bank");
  end

  // axi4-lite slave: write address and data taken together
  logic aw_hit_ctrl, aw_hit_stat, aw_ok, wr_take;
  assign wr_take = awvalid && wvalid && !bvalid;
  assign awready = wr_take;
  assign wready = wr_take;
  assign aw_hit_ctrl = awaddr == CTRL_OFS;
  assign aw_hit_stat = awaddr == STAT_OFS;
  assign aw_ok = aw_hit_ctrl || aw_hit_stat || awaddr == MPR2_OFS
                 || awaddr == MPR3_OFS || awaddr[7:6] == REP_PAGE;
  assign stat_clr = wr_take && aw_hit_stat && wstrb[0]
                    && wdata[STAT_DONE_BIT];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_take && aw_hit_ctrl) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb[i]) begin
          ctrl_ff[8*i +: 8] <= wdata[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= RESP_OK;
    end else if (wr_take) begin
      bvalid <= 1'b1;
      bresp <= aw_ok ? RESP_OK : RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (araddr[7:6] == REP_PAGE) begin
      rd_mux = {rep_valid[araddr[5:2]], 13'h0000, rep_row[araddr[5:2]]};
    end else begin
      case (araddr)
        CTRL_OFS: rd_mux = ctrl_ff;
        STAT_OFS: begin
          rd_mux[STAT_MODE_BIT] = mode_ff;
          rd_mux[3:1] = st_ff;
          rd_mux[STAT_DONE_BIT] = done_ff;
          rd_mux[STAT_UNDEF_BIT] = undef_ff;
          rd_mux[STAT_REFERR_BIT] = referr_ff;
          rd_mux[STAT_OPEN_LSB +: NBANK] = open_ff;
        end
        MPR2_OFS: rd_mux = {24'h00_0000, ctrl_ff[CTRL_HARD_BIT],
                            ctrl_ff[CTRL_SOFT_BIT], 6'h00};
        MPR3_OFS: rd_mux = {24'h00_0000, ctrl_ff[CTRL_MBIST_BIT],
                            7'h00};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  assign arready = !rvalid;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OK;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_ok ? RESP_OK : RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_key_break_idle: assert property (st_ff == ST_KEYS && !mr4_wr
    && !key_ok && cmd != CMD_NONE |=> st_ff == ST_IDLE)
    else $error("interrupted key sequence did not drop repair");
  a_keys_arm: assert property (st_ff == ST_KEYS && key_ok
    && key_idx_ff == 2'd3 && !mr4_wr |=> st_ff == ST_ARMED)
    else $error("fourth key did not arm repair");
  a_mode_follows: assert property (mr4_wr
    |=> mode_ff == $past(pins_s_ff.addr[MR4_SPPR_BIT]))
    else $error("repair mode flag wrong after mode write");
  a_commit_low: assert property (commit |-> all_low_ff
    && st_ff == ST_BURST)
    else $error("repair taken without all-low burst");
  a_high_no_repair: assert property (finish && all_high_ff
    |=> !done_ff && !undef_ff)
    else $error("high burst gave repair or undefined");
  a_entry_kept: assert property (commit
    |=> rep_valid[$past(tbank_ff)] && rep_row[$past(tbank_ff)]
        == $past(trow_ff))
    else $error("repair entry not stored");
  a_act_opens: assert property (cmd == CMD_ACT |=> open_ff[$past(bank)])
    else $error("activate did not open bank");
  a_ref_flag: assert property (cmd == CMD_REF && mode_ff
    |=> referr_ff)
    else $error("refresh in repair mode not flagged");

  c_repair_done: cover property (commit);
  c_key_break: cover property (st_ff == ST_KEYS ##1 st_ff == ST_IDLE);
  c_high_burst: cover property (finish && all_high_ff);
  c_undef_burst: cover property (finish && !commit && !all_high_ff);
endmodule : srr_core

`default_nettype wire

// >>> srr_host.sv
// controller-side model that drives the sdram clock and command pins
`timescale 1ns/100ps
`default_nettype none
module srr_host #(
  parameter int GAP_CK = 3
) (
  output logic ck,
  output var srr_pkg::srr_pins_type pins
);
  import srr_pkg::*;
  initial begin
    ck = 1'b0;
    pins = '{1'b1, 1'b1, 2'h0, 2'h0, 18'h0_0000, 8'h5A};
    #53;
    // free running, offset so its edges never meet clk edges
    forever #40 ck = ~ck;
  end
  task automatic cmd(input logic act, input logic [3:0] bank,
                     input logic [17:0] a);
    repeat (GAP_CK) @(posedge ck);
    @(negedge ck);
    pins.cs_n <= 1'b0;
    pins.act_n <= act;
    pins.bg <= bank[3:2];
    pins.ba <= bank[1:0];
    pins.addr <= a;
    @(negedge ck);
    // released lines flip so a stale command never looks valid
    pins.cs_n <= 1'b1;
    pins.act_n <= 1'b1;
    pins.bg <= ~bank[3:2];
    pins.ba <= ~bank[1:0];
    pins.addr <= ~a;
  endtask : cmd
  // call straight after cmd of the write; beat 0 first
  task automatic burst(input logic [4:0] wl, input logic [63:0] beats);
    #(wl * 80 - 60);
    for (int i = 0; i < 8; i++) begin
      pins.dq <= beats[63 - 8 * i -: 8];
      #40;
    end
    pins.dq <= ~pins.dq;
  endtask : burst
endmodule : srr_host
`default_nettype wire

// >>> srr_core_bench.sv
// self-checking bench for the soft row repair block
`timescale 1ns/100ps
`default_nettype none
module srr_core_bench;
  import srr_pkg::*;
  localparam logic [17:0] ROW_A = 18'h2_1234;
  localparam logic [17:0] ROW_B = 18'h0_ABCD;
  localparam logic [4:0] WL = 5'h03;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } srr_row_type;
  srr_row_type rows [6] = '{'{CTRL_OFS, CTRL_RST, RESP_OK},
    '{STAT_OFS, 32'h0000_0000, RESP_OK}, '{MPR2_OFS, 32'h0000_00C0, RESP_OK},
    '{MPR3_OFS, 32'h0000_0000, RESP_OK}, '{8'h4C, 32'h0000_0000, RESP_OK},
    '{8'h10, 32'h0000_0000, RESP_ERR}};
  logic [4:0] key_list [4] = '{KEY1, KEY2, KEY3, KEY4};
  logic clk, reset, ck, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  srr_pins_type pins;
  int err_total, check_count;
  srr_host host (.ck(ck), .pins(pins));
  srr_core dut (.clk(clk), .reset(reset), .ck(ck), .cs_n(pins.cs_n),
    .act_n(pins.act_n), .bg(pins.bg), .ba(pins.ba), .addr(pins.addr),
    .dq(pins.dq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    if (err_total == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, exp);
    axi_rd(a);
    chk(nm, d & m, exp);
  endtask : rd_chk
  // banks are idle here and only sequence commands go out
  task automatic repair(input logic [3:0] bank, input logic [17:0] row,
                        input int nkeys, input bit swap,
                        input logic [63:0] beats);
    host.cmd(1'b1, 4'h4, 18'h0_0020);
    rd_chk("mode on", STAT_OFS, 32'h0000_0001, 32'h0000_0001);
    for (int i = 0; i < nkeys; i++)
      host.cmd(1'b1, 4'h0, {6'h00, key_list[(swap && i < 2) ? 1 - i : i],
               KEY_LOW});
    host.cmd(1'b0, bank, row);
    host.cmd(1'b1, bank, 18'h1_0000);
    host.burst(WL, beats);
    host.cmd(1'b1, bank, 18'h0_8000);
    host.cmd(1'b1, 4'h4, 18'h0_0000);
    repeat (4) @(posedge ck);
  endtask : repair
  initial begin
    #500_000;
    err_total++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      axi_rd(rows[i].a);
      chk("reset read", d, rows[i].d);
      chk("read resp", {30'h0, r}, {30'h0, rows[i].r});
    end
    axi_wr(CTRL_OFS, 32'h0000_0303);
    rd_chk("ctrl", CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0303);
    repair(4'h3, ROW_A, 4, 0, 64'h0);
    rd_chk("done", STAT_OFS, 32'h0000_0031, 32'h0000_0010);
    rd_chk("entry", 8'h4C, 32'hFFFF_FFFF, {1'b1, 13'h0, ROW_A});
    axi_wr(STAT_OFS, 32'h0000_0010);
    repair(4'h5, ROW_B, 4, 1, 64'h0);
    rd_chk("swapped", 8'h54, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk("swap flags", STAT_OFS, 32'h0000_0030, 32'h0000_0000);
    repair(4'h3, ROW_B, 4, 0, 64'hFFFF_FFFF_0000_0000);
    rd_chk("high", STAT_OFS, 32'h0000_0030, 32'h0000_0000);
    repair(4'h3, ROW_B, 4, 0, 64'h00FF_0000_0000_0000);
    rd_chk("mixed", STAT_OFS, 32'h0000_0030, 32'h0000_0020);
    rd_chk("kept", 8'h4C, 32'hFFFF_FFFF, {1'b1, 13'h0, ROW_A});
    axi_wr(STAT_OFS, 32'h0000_0010);
    repair(4'h3, ROW_B, 4, 0, 64'h0);
    rd_chk("replaced", 8'h4C, 32'hFFFF_FFFF, {1'b1, 13'h0, ROW_B});
    // refresh inside repair mode on purpose
    host.cmd(1'b1, 4'h4, 18'h0_0020);
    host.cmd(1'b1, 4'h0, 18'h0_4000);
    host.cmd(1'b1, 4'h4, 18'h0_0000);
    rd_chk("ref in mode", STAT_OFS, 32'h0000_0040, 32'h0000_0040);
    axi_wr(STAT_OFS, 32'h0000_0010);
    host.cmd(1'b1, 4'h0, 18'h0_4000);
    host.cmd(1'b0, 4'h1, ROW_A);
    rd_chk("open", STAT_OFS, 32'h0002_0040, 32'h0002_0000);
    host.cmd(1'b1, 4'h0, 18'h0_4000);
    rd_chk("ref open", STAT_OFS, 32'h0000_0040, 32'h0000_0040);
    host.cmd(1'b1, 4'h1, 18'h1_0400);
    fork
      host.burst(WL, 64'h1234_5678_9ABC_DEF0);
      rd_chk("ap held", STAT_OFS, 32'h0002_0000, 32'h0002_0000);
    join
    repeat (4) @(posedge ck);
    rd_chk("ap closed", STAT_OFS, 32'h0002_0000, 32'h0000_0000);
    host.cmd(1'b1, 4'h2, 18'h0_8000);
    host.cmd(1'b1, 4'h2, 18'h0_8000);
    host.cmd(1'b0, 4'h2, ROW_B);
    rd_chk("reopen", STAT_OFS, 32'h0004_0000, 32'h0004_0000);
    host.cmd(1'b1, 4'h2, 18'h1_4400);
    repeat (12) @(posedge ck);
    rd_chk("rd ap", STAT_OFS, 32'h0004_0000, 32'h0000_0000);
    host.cmd(1'b1, 4'h0, 18'h0_8400);
    rd_chk("all closed", STAT_OFS, 32'hFFFF_0000, 32'h0000_0000);
    axi_wr(CTRL_OFS, 32'h0000_030F);
    rd_chk("mpr3", MPR3_OFS, 32'hFFFF_FFFF, 32'h0000_0080);
    repair(4'h7, ROW_A, 0, 0, 64'h0);
    rd_chk("no keys", 8'h5C, 32'hFFFF_FFFF, {1'b1, 13'h0, ROW_A});
    axi_wr(8'h10, 32'hFFFF_FFFF);
    chk("bad write", {30'h0, r}, {30'h0, RESP_ERR});
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk("after reset", 8'h4C, 32'hFFFF_FFFF, 32'h0000_0000);
    test_done();
  end
endmodule : srr_core_bench
`default_nettype wire
